// ### synth_freq_load_sequencer.sv
// frequency load sequencer: button-started nine-word load over an active-low BCD bus
// assumes button and thumbwheel pins are asynchronous; the far end samples on load_o
`timescale 1ns/1ps
`include "sfl_defs.svh"

module synth_freq_load_sequencer #(
   parameter int WORD_W = `SFL_WORD_W,
   parameter int FIFO_DEPTH = `SFL_FIFO_DEPTH
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic set_btn_i,
   input wire logic [WORD_W-1:0] thumb_digits_i,
   output logic [WORD_W-1:0] bus_n_o,
   output logic reset_o,
   output logic load_o,
   output logic busy_o,
   output logic done_o
);

   localparam int TICK_CYC = `SFL_TICK_CYC;

   sfl_pkg::seq_state_e seq_q;
   sfl_pkg::out_state_e out_q;
   logic btn_s1_q;
   logic btn_s2_q;
   logic btn_s3_q;
   logic [WORD_W-1:0] thumb_s1_q;
   logic [WORD_W-1:0] thumb_s2_q;
   logic [WORD_W-1:0] lat_q;
   logic [7:0] tick_cnt_q;
   logic tick_q;
   logic [7:0] seq_tmr_q;
   logic [7:0] out_tmr_q;
   logic [7:0] out_lim;
   logic [3:0] load_cnt_q;
   logic [3:0] gen_cnt_q;
   logic press;
   logic rst_done;
   logic run_done;
   logic ph_end;
   logic gen_valid;
   logic [WORD_W-1:0] gen_data;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [WORD_W-1:0] fifo_out_data;

   // pins pass two flops; edge detect compares stage two with stage three
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         btn_s1_q <= 1'b0;
         btn_s2_q <= 1'b0;
         btn_s3_q <= 1'b0;
      end else begin
         btn_s1_q <= set_btn_i;
         btn_s2_q <= btn_s1_q;
         btn_s3_q <= btn_s2_q;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         thumb_s1_q <= '0;
         thumb_s2_q <= '0;
      end else begin
         thumb_s1_q <= thumb_digits_i;
         thumb_s2_q <= thumb_s1_q;
      end
   end

   // presses during a sequence are ignored, not queued
   assign press = btn_s2_q && !btn_s3_q && (seq_q == sfl_pkg::SEQ_IDLE);

   // timing base: one-cycle enable every TICK_CYC clocks
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         tick_cnt_q <= 8'h00;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == 8'(TICK_CYC - 1)) begin
         tick_cnt_q <= 8'h00;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 8'h01;
         tick_q <= 1'b0;
      end
   end

   assign rst_done = (seq_q == sfl_pkg::SEQ_RESET) && tick_q &&
                     (seq_tmr_q == 8'(`SFL_RESET_TICKS - 1));
   assign run_done = (seq_q == sfl_pkg::SEQ_RUN) &&
                     (load_cnt_q == 4'(`SFL_WORD_COUNT)) && (out_q == sfl_pkg::OUT_IDLE);

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         seq_q <= sfl_pkg::SEQ_IDLE;
      end else begin
         unique case (seq_q)
            sfl_pkg::SEQ_IDLE: begin
               if (press) begin
                  seq_q <= sfl_pkg::SEQ_RESET;
               end
            end
            sfl_pkg::SEQ_RESET: begin
               if (rst_done) begin
                  seq_q <= sfl_pkg::SEQ_RUN;
               end
            end
            sfl_pkg::SEQ_RUN: begin
               if (run_done) begin
                  seq_q <= sfl_pkg::SEQ_IDLE;
               end
            end
            default: begin
               seq_q <= sfl_pkg::SEQ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i || seq_q != sfl_pkg::SEQ_RESET) begin
         seq_tmr_q <= 8'h00;
      end else if (tick_q) begin
         seq_tmr_q <= seq_tmr_q + 8'h01;
      end
   end

   // one start pulse: far-end reset and latch strobe together
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         reset_o <= 1'b0;
      end else if (press) begin
         reset_o <= 1'b1;
      end else if (rst_done) begin
         reset_o <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         lat_q <= '0;
      end else if (press) begin
         lat_q <= thumb_s2_q;
      end else if (ph_end && out_q == sfl_pkg::OUT_PULSE && load_cnt_q == 4'h1) begin
         lat_q <= '0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         busy_o <= 1'b0;
      end else if (press) begin
         busy_o <= 1'b1;
      end else if (run_done) begin
         busy_o <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= run_done;
      end
   end

   // word source: first word from latches, the rest all zero digits
   assign gen_valid = (gen_cnt_q < 4'(`SFL_WORD_COUNT)) && (seq_q == sfl_pkg::SEQ_RUN);
   assign gen_data = (gen_cnt_q == 4'h0) ? lat_q : '0;

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         gen_cnt_q <= 4'(`SFL_WORD_COUNT);
      end else if (rst_done) begin
         gen_cnt_q <= 4'h0;
      end else if (gen_valid && fifo_in_ready) begin
         gen_cnt_q <= gen_cnt_q + 4'h1;
      end
   end

   sfl_word_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .in_valid_i(gen_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(gen_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data)
   );

   // counter parked at nine means generator off
   assign fifo_out_ready = (out_q == sfl_pkg::OUT_IDLE) && (seq_q == sfl_pkg::SEQ_RUN) &&
                           (load_cnt_q < 4'(`SFL_WORD_COUNT));

   always_comb begin
      unique case (out_q)
         sfl_pkg::OUT_SETUP: out_lim = 8'(`SFL_SETUP_TICKS);
         sfl_pkg::OUT_PULSE: out_lim = 8'(`SFL_LOAD_TICKS);
         sfl_pkg::OUT_HOLD: out_lim = 8'(`SFL_HOLD_TICKS);
         default: out_lim = 8'h01;
      endcase
   end

   assign ph_end = tick_q && (out_tmr_q == out_lim - 8'h01);

   always_ff @(posedge mclk_i) begin
      if (srst_i || out_q == sfl_pkg::OUT_IDLE || ph_end) begin
         out_tmr_q <= 8'h00;
      end else if (tick_q) begin
         out_tmr_q <= out_tmr_q + 8'h01;
      end
   end

   // load pulse generator: setup, pulse, hold per word
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         out_q <= sfl_pkg::OUT_IDLE;
      end else begin
         unique case (out_q)
            sfl_pkg::OUT_IDLE: begin
               if (fifo_out_ready && fifo_out_valid) begin
                  out_q <= sfl_pkg::OUT_SETUP;
               end
            end
            sfl_pkg::OUT_SETUP: begin
               if (ph_end) begin
                  out_q <= sfl_pkg::OUT_PULSE;
               end
            end
            sfl_pkg::OUT_PULSE: begin
               if (ph_end) begin
                  out_q <= sfl_pkg::OUT_HOLD;
               end
            end
            sfl_pkg::OUT_HOLD: begin
               if (ph_end) begin
                  out_q <= sfl_pkg::OUT_IDLE;
               end
            end
            default: begin
               out_q <= sfl_pkg::OUT_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         bus_n_o <= '1;
      end else if (fifo_out_ready && fifo_out_valid) begin
         bus_n_o <= ~fifo_out_data;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         load_o <= 1'b0;
      end else if (ph_end && out_q == sfl_pkg::OUT_SETUP) begin
         load_o <= 1'b1;
      end else if (ph_end && out_q == sfl_pkg::OUT_PULSE) begin
         load_o <= 1'b0;
      end
   end

   // cleared only once reset has ended; sits at nine outside the run
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         load_cnt_q <= 4'(`SFL_WORD_COUNT);
      end else if (rst_done) begin
         load_cnt_q <= 4'h0;
      end else if (ph_end && out_q == sfl_pkg::OUT_SETUP) begin
         load_cnt_q <= load_cnt_q + 4'h1;
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);

   sequence reset_held_s;
      reset_o [*8] ##1 !load_o;
   endsequence

   sequence load_framed_s;
      $stable(bus_n_o) [*8];
   endsequence

   start_seq_a: assert property (press |=> reset_o && busy_o)
      else $error("button press did not start sequence");
   reset_capt_a: assert property ($rose(reset_o) |-> lat_q == $past(thumb_s2_q))
      else $error("digits not captured with reset pulse");
   reset_width_a: assert property ($rose(reset_o) |-> reset_held_s)
      else $error("reset pulse too short or overlapped load");
   cnt_clear_a: assert property ($fell(reset_o) |-> load_cnt_q == 4'h0 && !load_o)
      else $error("counter not cleared when reset ended");
   first_word_a: assert property ($rose(load_o) && load_cnt_q == 4'h1 |-> bus_n_o == ~lat_q)
      else $error("first word is not inverted latch data");
   zero_words_a: assert property ($rose(load_o) && load_cnt_q > 4'h1 |-> bus_n_o == '1)
      else $error("later word carries non-zero digits");
   latch_clear_a: assert property ($fell(load_o) && load_cnt_q == 4'h1 |-> lat_q == '0)
      else $error("latches not cleared after first load");
   load_stable_a: assert property ($rose(load_o) |-> load_framed_s)
      else $error("bus changed during load pulse");
   setup_hold_a: assert property ($rose(load_o) |-> $past(bus_n_o) == bus_n_o)
      else $error("bus changed at load rising edge");
   count_cap_a: assert property (load_cnt_q <= 4'(`SFL_WORD_COUNT))
      else $error("more than nine load pulses");
   idle_quiet_a: assert property (seq_q == sfl_pkg::SEQ_IDLE |-> !load_o && !reset_o)
      else $error("pulse emitted while idle");
   done_nine_a: assert property (done_o |-> load_cnt_q == 4'(`SFL_WORD_COUNT) && !load_o)
      else $error("done without nine words");

endmodule

// ### sfl_defs.svh
// timing and sizing constants for the frequency load sequencer
// assumes a single 250 MHz clock; all times below are in ns
`ifndef SFL_DEFS_SVH
`define SFL_DEFS_SVH

`define SFL_CLK_PERIOD_NS 4
`define SFL_TICK_NS 100
`define SFL_TICK_CYC ((`SFL_TICK_NS + `SFL_CLK_PERIOD_NS - 1) / `SFL_CLK_PERIOD_NS)

`define SFL_RESET_NS 2000
`define SFL_SETUP_NS 500
`define SFL_LOAD_NS 1000
`define SFL_HOLD_NS 500

`define SFL_RESET_TICKS ((`SFL_RESET_NS + `SFL_TICK_NS - 1) / `SFL_TICK_NS)
`define SFL_SETUP_TICKS ((`SFL_SETUP_NS + `SFL_TICK_NS - 1) / `SFL_TICK_NS)
`define SFL_LOAD_TICKS ((`SFL_LOAD_NS + `SFL_TICK_NS - 1) / `SFL_TICK_NS)
`define SFL_HOLD_TICKS ((`SFL_HOLD_NS + `SFL_TICK_NS - 1) / `SFL_TICK_NS)

`define SFL_WORD_COUNT 9
`define SFL_WORD_W 16
`define SFL_FIFO_DEPTH 16

`endif

// ### sfl_pkg.sv
// state types for the frequency load sequencer
// holds types only; numbers live in sfl_defs.svh
package sfl_pkg;

   typedef enum logic [2:0] {
      SEQ_IDLE  = 3'b001,
      SEQ_RESET = 3'b010,
      SEQ_RUN   = 3'b100
   } seq_state_e;

   typedef enum logic [3:0] {
      OUT_IDLE  = 4'b0001,
      OUT_SETUP = 4'b0010,
      OUT_PULSE = 4'b0100,
      OUT_HOLD  = 4'b1000
   } out_state_e;

endpackage

// ### sfl_word_fifo.sv
// synchronous word fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module sfl_word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_ptr_q;
   logic [AW:0] rd_ptr_q;
   logic push;
   logic pop;

   // extra pointer bit separates full from empty
   assign in_ready_o = (wr_ptr_q[AW] == rd_ptr_q[AW]) || (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]);
   assign out_valid_o = (wr_ptr_q != rd_ptr_q);
   assign out_data_o = mem_q[rd_ptr_q[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         wr_ptr_q <= '0;
      end else if (push) begin
         wr_ptr_q <= wr_ptr_q + (AW+1)'(1);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rd_ptr_q <= '0;
      end else if (pop) begin
         rd_ptr_q <= rd_ptr_q + (AW+1)'(1);
      end
   end

endmodule

// ### synth_ctrl_model.sv
// far-end model of the synthesizer frequency control interface
// assumes registered bus and strobes from the sequencer on the same clock
`timescale 1ns/1ps

module synth_ctrl_model (
   input wire logic mclk_i,
   input wire logic [15:0] bus_n_i,
   input wire logic reset_i,
   input wire logic load_i,
   output logic [3:0] word_cnt_o,
   output logic [39:0] freq_o,
   output logic apply_o
);
   logic load_q;
   logic [39:0] reg_q;
   logic [15:0] word;

   assign word = ~bus_n_i;

   always_ff @(posedge mclk_i) begin
      load_q <= load_i;
      apply_o <= 1'b0;
      if (reset_i) begin
         word_cnt_o <= 4'h0;
         reg_q <= 40'h0;
      end else if (load_i && !load_q) begin
         word_cnt_o <= word_cnt_o + 4'h1;
         case (word_cnt_o)
            4'h0: reg_q[39:24] <= word;
            4'h1: reg_q[23:8] <= word;
            4'h2: reg_q[7:0] <= word[15:8];
            default: ;
         endcase
         // words 4..9 are discarded by the default arm; low digits of word 3 dropped
         if (word_cnt_o == 4'h8) begin
            freq_o <= reg_q;
            apply_o <= 1'b1;
         end
      end
   end

endmodule

// ### testbench.sv
// self-checking bench: sequencer driving the far-end interface model
// assumes the sequencer and model sources are compiled before this file
`timescale 1ns/1ps

module testbench;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic set_btn_i = 1'b0;
   logic [15:0] thumb_digits_i = 16'h0000;
   logic [15:0] bus_n_o;
   logic reset_o;
   logic load_o;
   logic busy_o;
   logic done_o;
   logic [3:0] word_cnt;
   logic [39:0] freq;
   logic apply;
   logic load_d = 1'b0;
   logic reset_d = 1'b0;
   logic [15:0] bus_at_load;
   logic [15:0] exp_q[$];
   logic [39:0] freq_q[$];
   logic [15:0] digit_tab[3];
   int n_mismatch = 0;
   int checks = 0;
   int n_resets = 0;
   int n_loads = 0;

   always #2 mclk_i = ~mclk_i;

   synth_freq_load_sequencer synth_freq_load_sequencer_inst (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .set_btn_i(set_btn_i),
      .thumb_digits_i(thumb_digits_i),
      .bus_n_o(bus_n_o),
      .reset_o(reset_o),
      .load_o(load_o),
      .busy_o(busy_o),
      .done_o(done_o)
   );

   synth_ctrl_model synth_ctrl_model_inst (
      .mclk_i(mclk_i),
      .bus_n_i(bus_n_o),
      .reset_i(reset_o),
      .load_i(load_o),
      .word_cnt_o(word_cnt),
      .freq_o(freq),
      .apply_o(apply)
   );

   task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   function automatic logic [15:0] rand_bcd();
      return {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10)};
   endfunction

   // one press, plus a second mid-sequence press unless hold; hold keeps the button down through the whole sequence
   task automatic run_seq(input logic [15:0] digits, input bit hold);
      @(posedge mclk_i);
      thumb_digits_i <= digits;
      exp_q.push_back(~digits);
      repeat (8) exp_q.push_back(16'hFFFF);
      freq_q.push_back({digits, 24'h0});
      repeat (4) @(posedge mclk_i);
      set_btn_i <= 1'b1;
      for (int i = 0; i < 20 && reset_o !== 1'b1; i++) @(negedge mclk_i);
      check("busy at start", 1'b1, busy_o);
      @(posedge mclk_i);
      thumb_digits_i <= rand_bcd();
      if (!hold) begin
         set_btn_i <= 1'b0;
         repeat (1500) @(posedge mclk_i);
         set_btn_i <= 1'b1;
         repeat (20) @(posedge mclk_i);
         set_btn_i <= 1'b0;
      end
      for (int i = 0; i < 8000 && done_o !== 1'b1; i++) @(negedge mclk_i);
      check("done pulse", 1'b1, done_o);
      @(negedge mclk_i);
      check("busy after done", 1'b0, busy_o);
      check("done width", 1'b0, done_o);
      @(posedge mclk_i);
      set_btn_i <= 1'b0;
      repeat (700) @(posedge mclk_i);
      check("queue drained", 0, exp_q.size());
      check("freq drained", 0, freq_q.size());
   endtask

   // monitor: the oldest expected word is taken at each load rise
   // samples on the falling edge, where registered outputs have settled
   always @(negedge mclk_i) begin
      load_d <= load_o;
      reset_d <= reset_o;
      if (load_o && !load_d) begin
         n_loads++;
         bus_at_load = bus_n_o;
         check("reset idle at load", 1'b0, reset_o);
         if (exp_q.size() == 0) begin
            check("extra load", 1'b0, 1'b1);
         end else begin
            check("bus word", exp_q.pop_front(), bus_n_o);
         end
      end
      if (load_o && load_d) begin
         check("bus stable", bus_at_load, bus_n_o);
      end
      if (reset_o && !reset_d) begin
         n_resets++;
         check("load idle in reset", 1'b0, load_o);
      end
      if (done_o === 1'b1) begin
         check("far words", 4'h9, word_cnt);
      end
      if (apply === 1'b1) begin
         if (freq_q.size() == 0) begin
            check("extra apply", 1'b0, 1'b1);
         end else begin
            check("applied freq", freq_q.pop_front(), freq);
         end
      end
   end

   initial begin
      repeat (60000) @(posedge mclk_i);
      n_mismatch++;
      $display("timeout waiting for sequencer");
      results();
   end

   initial begin
      void'($urandom(63));
      digit_tab[0] = rand_bcd();
      digit_tab[1] = 16'h9999;
      digit_tab[2] = 16'h0000;
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(negedge mclk_i);
      check("bus idle", 16'hFFFF, bus_n_o);
      check("load idle", 1'b0, load_o);
      for (int s = 0; s < 3; s++) begin
         run_seq(digit_tab[s], s == 1);
         check("reset pulses", s + 1, n_resets);
         check("load pulses", 9 * (s + 1), n_loads);
      end
      results();
   end

endmodule
